// [core/psrc_pkg.sv]
// Functional notes
// - Twelve relay outputs, each separately activated.
// - Relays grouped four per sensor module slot.
// - Single-sensor slot: all four follow channel one.
// - Dual-sensor slot: each channel drives two relays.
// - Relay contact open unless activated.
// - All relays held off during power-up.
// - Measurement to relay change within 50-100 ms.
// - Above direction: activate when pressure exceeds setpoint.
// - Below direction: activate when pressure under setpoint.
// - Ion gauge relays refuse the above direction.
// - Hysteresis on releasing side of the setpoint.
// - Direction change reloads hysteresis about ten percent.
package psrc_pkg;

   // ======================================================================
   // Sizes
   localparam int NUM_RELAY      = 12;
   localparam int RELAY_PER_SLOT = 4;
   localparam int NUM_SLOT       = 3;
   localparam int CH_PER_SLOT    = 2;
   localparam int NUM_CH         = 6;
   localparam int PW             = 16;
   localparam int AW             = 12;
   localparam int DLY_CW         = 24;
   localparam int CHW            = 3;

   // ======================================================================
   // Timing
   localparam int CLK_MHZ          = 250;
   localparam int RELAY_DELAY_MS   = 50;
   localparam int RELAY_DELAY_CYC  = RELAY_DELAY_MS * 1000 * CLK_MHZ;
   localparam int POWERUP_HOLD_MS  = 10;
   localparam int POWERUP_HOLD_CYC = POWERUP_HOLD_MS * 1000 * CLK_MHZ;

   // ======================================================================
   // Register map and fields
   localparam logic [AW-1:0] ADDR_SLOT_CFG   = 12'h000;
   localparam logic [AW-1:0] ADDR_DIR        = 12'h004;
   localparam logic [AW-1:0] ADDR_STATUS     = 12'h008;
   localparam logic [AW-1:0] ADDR_CH_SEEN    = 12'h00c;
   localparam logic [AW-1:0] ADDR_RELAY_BASE = 12'h040;
   localparam logic [AW-1:0] ADDR_RELAY_END  = 12'h070;
   localparam int CFG_DUAL_LSB     = 0;
   localparam int CFG_ION_LSB      = 4;
   localparam int STAT_READY_BIT   = 16;
   localparam int STAT_DIR_REF_BIT = 17;
   localparam int STAT_HYS_REF_BIT = 18;
   localparam int RLY_SP_LSB       = 0;
   localparam int RLY_HYS_LSB      = 16;

   // ======================================================================
   // Reset values and hysteresis default
   localparam logic [PW-1:0]        SP_RESET   = 16'h8000;
   localparam logic [PW-1:0]        HYS_RESET  = 16'h8d00;
   localparam logic [NUM_RELAY-1:0] DIR_RESET  = 12'h000;
   localparam logic [NUM_SLOT-1:0]  SLOT_RESET = 3'h0;
   localparam logic [7:0]           HYST_NUM   = 8'h1a;
   localparam int                   HYST_SHIFT = 8;
   localparam logic [1:0]           RESP_OKAY   = 2'h0;
   localparam logic [1:0]           RESP_SLVERR = 2'h2;

   // ======================================================================
   // Carriers
   typedef struct packed {
      logic          valid;
      logic [PW-1:0] value;
   } psrc_sample_t;

   typedef struct packed {
      logic          awvalid;
      logic [AW-1:0] awaddr;
      logic          wvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bready;
      logic          arvalid;
      logic [AW-1:0] araddr;
      logic          rready;
   } psrc_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } psrc_axi_rsp_t;

   typedef enum logic [1:0] {PU_HOLD, PU_WAIT, PU_RUN} psrc_pu_state_t;

endpackage : psrc_pkg

// [core/psrc_meas_delay.sv]
`timescale 1ns/10ps
module psrc_meas_delay #(
   parameter int DELAY_CYC = psrc_pkg::RELAY_DELAY_CYC // Cycles from sample to release.
) (
   input  wire logic                   clk_i,   // System clock.
   input  wire logic                   nrst_i,  // Asynchronous reset, active low.
   input  wire psrc_pkg::psrc_sample_t in_i,    // New measurement, valid is a pulse.
   output psrc_pkg::psrc_sample_t      out_o    // Delayed measurement, valid is a pulse.
);
   import psrc_pkg::*;

   localparam logic [DLY_CW-1:0] LAST = DLY_CW'(DELAY_CYC - 1);

   logic              busy;
   logic              pend;
   logic [PW-1:0]     cur;
   logic [PW-1:0]     nxt;
   logic [DLY_CW-1:0] cnt;
   psrc_sample_t      out;

   assign out_o = out;

   // ======================================================================
   // Delay line
   // A sample that lands while one is in flight waits for the running count,
   // so its total latency stays under twice the delay.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy <= 1'b0;
         pend <= 1'b0;
         cur  <= '0;
         nxt  <= '0;
         cnt  <= '0;
         out  <= '0;
      end else begin
         out.valid <= 1'b0;
         if (busy && cnt == LAST) begin
            out <= '{valid: 1'b1, value: cur};
            cnt <= '0;
            pend <= 1'b0;
            if (in_i.valid) begin
               cur <= in_i.value;
            end else if (pend) begin
               cur <= nxt;
            end else begin
               busy <= 1'b0;
            end
         end else if (busy) begin
            cnt <= cnt + 1'b1;
            if (in_i.valid) begin
               nxt  <= in_i.value;
               pend <= 1'b1;
            end
         end else if (in_i.valid) begin
            busy <= 1'b1;
            cur  <= in_i.value;
            cnt  <= '0;
         end
      end
   end

   chk_delay_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
      out.valid |-> $past(busy) && $past(cnt) == LAST)
      else $error("delayed sample released before its count ran out");

   chk_pend_restart: assert property (@(posedge clk_i) disable iff (!nrst_i)
      busy && cnt == LAST && pend && !in_i.valid |=> busy && cnt == '0 && cur == $past(nxt))
      else $error("pending sample did not start a new delay");

endmodule : psrc_meas_delay

// [core/psrc_relay_ctrl.sv]
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module psrc_relay_ctrl #(
   parameter int DELAY_CYC = psrc_pkg::RELAY_DELAY_CYC, // Measurement to relay delay.
   parameter int HOLD_CYC  = psrc_pkg::POWERUP_HOLD_CYC // Power-up hold time.
) (
   input  wire logic                                        clk_i,    // System clock.
   input  wire logic                                        nrst_i,   // Async reset, low.
   input  wire psrc_pkg::psrc_axi_req_t                     axi_i,    // AXI4-Lite request.
   output psrc_pkg::psrc_axi_rsp_t                          axi_o,    // AXI4-Lite answer.
   input  wire psrc_pkg::psrc_sample_t [psrc_pkg::NUM_CH-1:0] sample_i, // Channel samples.
   output logic [psrc_pkg::NUM_RELAY-1:0]                   relay_o   // High closes contact.
);
   import psrc_pkg::*;

   localparam logic [DLY_CW-1:0] HOLD_LAST = DLY_CW'(HOLD_CYC - 1);

   // ======================================================================
   // Declarations
   logic                 awready;
   logic                 wready;
   logic                 bvalid;
   logic [1:0]           bresp;
   logic                 arready;
   logic                 rvalid;
   logic [31:0]          rdata;
   logic [1:0]           rresp;
   logic                 aw_full;
   logic                 w_full;
   logic [AW-1:0]        awaddr_q;
   logic [31:0]          wdata_q;
   logic [3:0]           wstrb_q;
   logic                 wr_fire;
   logic                 wr_cfg;
   logic                 wr_dir;
   logic                 wr_stat;
   logic                 wr_rly;
   logic                 wr_ok;
   logic [3:0]           wr_idx;
   logic [AW-1:0]        wr_off;
   logic [NUM_SLOT-1:0]  slot_dual;
   logic [NUM_SLOT-1:0]  slot_ion;
   logic [NUM_SLOT-1:0]  next_dual;
   logic [NUM_SLOT-1:0]  next_ion;
   logic [NUM_RELAY-1:0] dir;
   logic [NUM_RELAY-1:0] next_dir;
   logic [NUM_RELAY-1:0] ion_rmask;
   logic [NUM_RELAY-1:0] next_ion_rmask;
   logic [31:0]          dir_merged;
   logic [NUM_RELAY-1:0] dir_req;
   logic                 dir_bad;
   logic                 hys_bad;
   logic                 dir_refused;
   logic                 hys_refused;
   logic [PW-1:0]        sp  [NUM_RELAY];
   logic [PW-1:0]        hys [NUM_RELAY];
   logic [PW-1:0]        new_sp;
   logic [PW-1:0]        new_hys;
   logic [31:0]          cfg_word;
   logic [31:0]          cfg_merged;
   logic [31:0]          rly_merged;
   logic [NUM_CH-1:0]    ch_seen;
   logic [NUM_CH-1:0]    ch_need;
   logic [NUM_RELAY-1:0] act;
   logic [DLY_CW-1:0]    hold_cnt;
   psrc_pu_state_t       pu_state;
   psrc_sample_t [NUM_CH-1:0] dly;

   assign axi_o.awready = awready;
   assign axi_o.wready  = wready;
   assign axi_o.bvalid  = bvalid;
   assign axi_o.bresp   = bresp;
   assign axi_o.arready = arready;
   assign axi_o.rvalid  = rvalid;
   assign axi_o.rdata   = rdata;
   assign axi_o.rresp   = rresp;

   function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // The default offset is setpoint times 26/256, a cheap stand-in for ten
   // percent that needs no divider; the upper side saturates at full scale.
   function automatic logic [PW-1:0] hys_default(input logic [PW-1:0] s, input logic above);
      logic [PW+7:0] prod;
      logic [PW-1:0] off;
      logic [PW:0]   sum;
      prod = {8'h00, s} * {{PW{1'b0}}, HYST_NUM};
      off  = prod[PW+HYST_SHIFT-1:HYST_SHIFT];
      sum  = {1'b0, s} + {1'b0, off};
      if (above) begin
         return s - off;
      end
      return sum[PW] ? {PW{1'b1}} : sum[PW-1:0];
   endfunction : hys_default

   // ======================================================================
   // Measurement delay per channel
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      psrc_meas_delay #(
         .DELAY_CYC (DELAY_CYC)
      ) u_dly (
         .clk_i  (clk_i),
         .nrst_i (nrst_i),
         .in_i   (sample_i[c]),
         .out_o  (dly[c])
      );
   end

   // ======================================================================
   // AXI4-Lite write channel
   assign wr_fire = aw_full && w_full && !bvalid;
   assign wr_off  = awaddr_q - ADDR_RELAY_BASE;
   assign wr_idx  = wr_off[5:2];
   assign wr_cfg  = awaddr_q == ADDR_SLOT_CFG;
   assign wr_dir  = awaddr_q == ADDR_DIR;
   assign wr_stat = awaddr_q == ADDR_STATUS;
   assign wr_rly  = awaddr_q >= ADDR_RELAY_BASE && awaddr_q < ADDR_RELAY_END
                    && awaddr_q[1:0] == 2'h0;
   assign wr_ok   = wr_cfg || wr_dir || wr_stat || wr_rly || awaddr_q == ADDR_CH_SEEN;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_full  <= 1'b0;
         w_full   <= 1'b0;
         awaddr_q <= '0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
         awready  <= 1'b1;
         wready   <= 1'b1;
         bvalid   <= 1'b0;
         bresp    <= RESP_OKAY;
      end else begin
         if (axi_i.awvalid && awready) begin
            aw_full  <= 1'b1;
            awaddr_q <= axi_i.awaddr;
            awready  <= 1'b0;
         end
         if (axi_i.wvalid && wready) begin
            w_full  <= 1'b1;
            wdata_q <= axi_i.wdata;
            wstrb_q <= axi_i.wstrb;
            wready  <= 1'b0;
         end
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && axi_i.bready) begin
            bvalid  <= 1'b0;
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // ======================================================================
   // Slot configuration and direction
   assign cfg_word   = {25'h0, slot_ion, 1'b0, slot_dual};
   assign cfg_merged = merge(cfg_word, wdata_q, wstrb_q);
   assign next_dual  = (wr_fire && wr_cfg) ? cfg_merged[CFG_DUAL_LSB +: NUM_SLOT] : slot_dual;
   assign next_ion   = (wr_fire && wr_cfg) ? cfg_merged[CFG_ION_LSB +: NUM_SLOT] : slot_ion;
   assign dir_merged = merge({20'h0, dir}, wdata_q, wstrb_q);
   assign dir_req    = dir_merged[NUM_RELAY-1:0];

   for (genvar r = 0; r < NUM_RELAY; r++) begin : g_mask
      assign ion_rmask[r]      = slot_ion[r / RELAY_PER_SLOT];
      assign next_ion_rmask[r] = next_ion[r / RELAY_PER_SLOT];
   end

   always_comb begin
      next_dir = dir;
      dir_bad  = 1'b0;
      if (wr_fire && wr_dir) begin
         next_dir = dir_req & ~ion_rmask;
         dir_bad  = |(dir_req & ion_rmask);
      end
      if (wr_fire && wr_cfg) begin
         next_dir = dir & ~next_ion_rmask;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         slot_dual <= SLOT_RESET;
         slot_ion  <= SLOT_RESET;
         dir       <= DIR_RESET;
      end else begin
         slot_dual <= next_dual;
         slot_ion  <= next_ion;
         dir       <= next_dir;
      end
   end

   // ======================================================================
   // Setpoint and hysteresis per relay
   assign rly_merged = merge({hys[wr_idx], sp[wr_idx]}, wdata_q, wstrb_q);
   assign new_sp     = rly_merged[RLY_SP_LSB +: PW];
   assign new_hys    = rly_merged[RLY_HYS_LSB +: PW];
   assign hys_bad    = wr_fire && wr_rly
                       && (dir[wr_idx] ? new_hys > new_sp : new_hys < new_sp);

   for (genvar r = 0; r < NUM_RELAY; r++) begin : g_sp
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            sp[r]  <= SP_RESET;
            hys[r] <= HYS_RESET;
         end else if (next_dir[r] != dir[r]) begin
            hys[r] <= hys_default(sp[r], next_dir[r]);
         end else if (wr_fire && wr_rly && wr_idx == 4'(r) && !hys_bad) begin
            sp[r]  <= new_sp;
            hys[r] <= new_hys;
         end
      end
   end

   // Refusal flags: a new refusal wins over a clear in the same write.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dir_refused <= 1'b0;
         hys_refused <= 1'b0;
      end else begin
         if (dir_bad) begin
            dir_refused <= 1'b1;
         end else if (wr_fire && wr_stat && wstrb_q[2] && wdata_q[STAT_DIR_REF_BIT]) begin
            dir_refused <= 1'b0;
         end
         if (hys_bad) begin
            hys_refused <= 1'b1;
         end else if (wr_fire && wr_stat && wstrb_q[2] && wdata_q[STAT_HYS_REF_BIT]) begin
            hys_refused <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Power-up hold
   for (genvar s = 0; s < NUM_SLOT; s++) begin : g_need
      assign ch_need[s*CH_PER_SLOT]     = 1'b1;
      assign ch_need[s*CH_PER_SLOT + 1] = slot_dual[s];
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ch_seen <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (dly[c].valid) begin
               ch_seen[c] <= 1'b1;
            end
         end
      end
   end

   // Relays stay open until the hold has run and every used channel has
   // delivered a delayed sample, so no trip is made on a reset-time value.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pu_state <= PU_HOLD;
         hold_cnt <= '0;
      end else begin
         unique case (pu_state)
            PU_HOLD: begin
               hold_cnt <= hold_cnt + 1'b1;
               if (hold_cnt == HOLD_LAST) begin
                  pu_state <= PU_WAIT;
               end
            end
            PU_WAIT: begin
               if ((ch_seen & ch_need) == ch_need) begin
                  pu_state <= PU_RUN;
               end
            end
            PU_RUN: begin
               pu_state <= PU_RUN;
            end
         endcase
      end
   end

   // ======================================================================
   // Trip decision per relay
   for (genvar r = 0; r < NUM_RELAY; r++) begin : g_rly
      localparam int S = r / RELAY_PER_SLOT;
      localparam int K = r % RELAY_PER_SLOT;
      logic [CHW-1:0] ch;
      psrc_sample_t   smp;
      logic           a;

      assign ch     = slot_dual[S] ? CHW'(S*CH_PER_SLOT + K/2) : CHW'(S*CH_PER_SLOT);
      assign smp    = dly[ch];
      assign act[r] = a;

      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            a <= 1'b0;
         end else if (next_dir[r] != dir[r]) begin
            a <= 1'b0;
         end else if (smp.valid && dir[r]) begin
            a <= a ? !(smp.value < hys[r]) : smp.value > sp[r];
         end else if (smp.valid) begin
            a <= a ? !(smp.value > hys[r]) : smp.value < sp[r];
         end
      end

      chk_trip_above: assert property (@(posedge clk_i) disable iff (!nrst_i)
         smp.valid && dir[r] && next_dir[r] && !a && smp.value > sp[r] |=> a)
         else $error("above relay did not trip over setpoint");

      chk_trip_below: assert property (@(posedge clk_i) disable iff (!nrst_i)
         smp.valid && !dir[r] && !next_dir[r] && !a && smp.value < sp[r] |=> a)
         else $error("below relay did not trip under setpoint");

      chk_hyst_release: assert property (@(posedge clk_i) disable iff (!nrst_i)
         a && smp.valid && (dir[r] ? smp.value < hys[r] : smp.value > hys[r]) |=> !a)
         else $error("relay held past its hysteresis level");

      chk_hyst_side: assert property (@(posedge clk_i) disable iff (!nrst_i)
         dir[r] ? hys[r] <= sp[r] : hys[r] >= sp[r])
         else $error("hysteresis on the wrong side of setpoint");

      chk_dir_reload: assert property (@(posedge clk_i) disable iff (!nrst_i)
         next_dir[r] != dir[r] |=> hys[r] == hys_default(sp[r], dir[r]))
         else $error("direction change did not reload hysteresis");
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         relay_o <= '0;
      end else begin
         relay_o <= act & {NUM_RELAY{pu_state == PU_RUN}};
      end
   end

   // ======================================================================
   // AXI4-Lite read channel
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (axi_i.arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= RESP_OKAY;
         rdata   <= '0;
         if (axi_i.araddr == ADDR_SLOT_CFG) begin
            rdata <= cfg_word;
         end else if (axi_i.araddr == ADDR_DIR) begin
            rdata <= {20'h0, dir};
         end else if (axi_i.araddr == ADDR_STATUS) begin
            rdata <= {13'h0, hys_refused, dir_refused, pu_state == PU_RUN, 4'h0, relay_o};
         end else if (axi_i.araddr == ADDR_CH_SEEN) begin
            rdata <= {26'h0, ch_seen};
         end else if (axi_i.araddr >= ADDR_RELAY_BASE && axi_i.araddr < ADDR_RELAY_END
                      && axi_i.araddr[1:0] == 2'h0) begin
            rdata <= {hys[4'((axi_i.araddr - ADDR_RELAY_BASE) >> 2)],
                      sp[4'((axi_i.araddr - ADDR_RELAY_BASE) >> 2)]};
         end else begin
            rresp <= RESP_SLVERR;
         end
      end else if (rvalid && axi_i.rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ======================================================================
   // Bus, power-up and ion gauge direction checks
   sequence s_wr_both;
      aw_full && w_full && !bvalid;
   endsequence

   sequence s_rd_take;
      axi_i.arvalid && arready;
   endsequence

   chk_wr_answer: assert property (@(posedge clk_i) disable iff (!nrst_i)
      s_wr_both |=> bvalid && !awready && !wready)
      else $error("write answer not raised one cycle after both halves");

   chk_rd_answer: assert property (@(posedge clk_i) disable iff (!nrst_i)
      s_rd_take |=> rvalid && !arready)
      else $error("read answer not raised one cycle after address");

   chk_relay_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      pu_state != PU_RUN |=> relay_o == '0)
      else $error("relay closed before power-up completed");

   chk_relay_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
      pu_state == PU_RUN |=> relay_o == $past(act))
      else $error("relay output does not follow its decision");

   chk_ion_below: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (dir & ion_rmask) == '0)
      else $error("ion gauge relay set to above direction");

endmodule : psrc_relay_ctrl

// [verif/psrc_valve_model.sv]
`timescale 1ns/10ps
module psrc_valve_model (
   input  wire logic [11:0] relay_i, // Relay activate levels.
   output logic      [11:0] open_o   // Valve solenoid powered.
);
   // ======================================================================
   // Contacts
   // A normally open contact powers its valve only while the relay is active.
   assign open_o = relay_i;
endmodule : psrc_valve_model

// [verif/pressure_setpoint_relay_control_tb.sv]
`timescale 1ns/10ps
module pressure_setpoint_relay_control_tb;
   import psrc_pkg::*;
   localparam int D = 20;
   logic                      clk_i = 1'b0;
   logic                      nrst_i = 1'b0;
   psrc_axi_req_t             req = '{bready: 1'b1, rready: 1'b1, default: '0};
   psrc_axi_rsp_t             rsp;
   psrc_sample_t [NUM_CH-1:0] smp = '0;
   logic [11:0]               rly, vlv, dirv, act, old;
   logic [15:0]               sp [12];
   logic [15:0]               hy [12];
   logic [15:0]               v [6];
   logic [31:0]               d;
   logic [1:0]                rs;
   int                        errors = 0;
   int                        total_checks = 0;
   int                        cyc = 0;

   always #2 clk_i = ~clk_i;

   psrc_relay_ctrl #(.DELAY_CYC(D), .HOLD_CYC(10)) i_psrc_relay_ctrl (.clk_i(clk_i),
      .nrst_i(nrst_i), .axi_i(req), .axi_o(rsp), .sample_i(smp), .relay_o(rly));
   psrc_valve_model i_psrc_valve_model (.relay_i(rly), .open_o(vlv));

   // ======================================================================
   // Helpers
   task automatic end_of_test();
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic axw(input logic [11:0] a, input logic [31:0] dt, output logic [1:0] r);
      req.awaddr <= a;
      req.wdata <= dt;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (rsp.bvalid) break;
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end
      r = rsp.bresp;
   endtask : axw

   task automatic axr(input logic [11:0] a, output logic [31:0] dt, output logic [1:0] r);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (rsp.rvalid) break;
         if (rsp.arready) req.arvalid <= 1'b0;
      end
      dt = rsp.rdata;
      r = rsp.rresp;
   endtask : axr

   // Slot 0 single, slot 1 dual, slot 2 single ion gauge.
   task automatic model();
      int c;
      for (int r = 0; r < 12; r++) begin
         c = (r / 4 == 1) ? 2 + (r % 4) / 2 : 2 * (r / 4);
         if (dirv[r]) act[r] = act[r] ? !(v[c] < hy[r]) : (v[c] > sp[r]);
         else act[r] = act[r] ? !(v[c] > hy[r]) : (v[c] < sp[r]);
      end
   endtask : model

   task automatic round();
      old = act;
      model();
      for (int c = 0; c < 6; c++) smp[c] <= {1'b1, v[c]};
      @(posedge clk_i);
      smp <= '0;
      // A repeat of the same values lands mid-delay, so it waits as a pending sample.
      repeat (4) @(posedge clk_i);
      for (int c = 0; c < 6; c++) smp[c] <= {1'b1, v[c]};
      @(posedge clk_i);
      smp <= '0;
      repeat (D - 4) @(posedge clk_i);
      #1 chk(vlv, old);
      @(posedge clk_i);
      #1 chk(vlv, act);
      repeat (D) @(posedge clk_i);
      model();
      #1 chk(vlv, act);
      @(posedge clk_i);
   endtask : round

   // ======================================================================
   // Watchdog
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         end_of_test();
      end
   end

   // ======================================================================
   // Sequence
   initial begin
      d = $urandom(91);
      act = '0;
      dirv = '0;
      for (int r = 0; r < 12; r++) begin
         sp[r] = SP_RESET;
         hy[r] = HYS_RESET;
      end
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      chk(vlv, 0);
      axw(ADDR_SLOT_CFG, 32'h42, rs);
      // Samples at the setpoint trip nothing, they only end the power-up wait.
      for (int c = 0; c < 6; c++) v[c] = 16'h8000;
      round();
      axr(ADDR_STATUS, d, rs);
      chk(d[16], 1'b1);
      dirv = (12'($urandom) | 12'h100) & 12'hffe;
      axw(ADDR_DIR, {20'h0, dirv}, rs);
      dirv[11:8] = 4'h0;
      axr(ADDR_DIR, d, rs);
      chk(d, {20'h0, dirv});
      axr(ADDR_STATUS, d, rs);
      chk(d[17], 1'b1);
      for (int r = 0; r < 12; r++) begin
         hy[r] = dirv[r] ? 16'h8000 - 16'h0d00 : 16'h8d00;
         axr(ADDR_RELAY_BASE + 12'(4 * r), d, rs);
         chk(d, {hy[r], sp[r]});
         sp[r] = 16'h2000 + 16'($urandom % 32'hc000);
         d[15:0] = 16'($urandom % 32'h1000);
         hy[r] = dirv[r] ? sp[r] - d[15:0] : sp[r] + d[15:0];
         axw(ADDR_RELAY_BASE + 12'(4 * r), {hy[r], sp[r]}, rs);
      end
      axw(ADDR_RELAY_BASE, {sp[0] - 16'h0001, sp[0]}, rs);
      axr(ADDR_RELAY_BASE, d, rs);
      chk(d, {hy[0], sp[0]});
      axr(ADDR_STATUS, d, rs);
      chk(d[18], 1'b1);
      axr(12'h100, d, rs);
      chk(rs, RESP_SLVERR);
      axw(12'h100, 32'h1, rs);
      chk(rs, RESP_SLVERR);
      repeat (30) begin
         for (int c = 0; c < 6; c++) v[c] = 16'($urandom);
         round();
      end
      axr(ADDR_STATUS, d, rs);
      chk(d[11:0], act);
      axr(ADDR_CH_SEEN, d, rs);
      chk(d, 32'h3f);
      axw(ADDR_STATUS, 32'h60000, rs);
      axr(ADDR_STATUS, d, rs);
      chk(d[18:17], 2'h0);
      // Making slot zero an ion gauge forces its relays to the below direction.
      old = dirv;
      axw(ADDR_SLOT_CFG, 32'h52, rs);
      dirv[3:0] = 4'h0;
      axr(ADDR_DIR, d, rs);
      chk(d, {20'h0, dirv});
      for (int r = 0; r < 4; r++) begin
         if (old[r]) hy[r] = 16'(sp[r] + ((32'(sp[r]) * HYST_NUM) >> HYST_SHIFT));
         axr(ADDR_RELAY_BASE + 12'(4 * r), d, rs);
         chk(d, {hy[r], sp[r]});
      end
      end_of_test();
   end
endmodule : pressure_setpoint_relay_control_tb
